/* File: hdl/extended_nvm_shadow_access.sv */
`timescale 1ns/100ps
module extended_nvm_shadow_access
  import nvm_access_pkg::*;
#(
  parameter int WRITE_CYCLES = NVM_WRITE_CYCLES,
  parameter int READ_CYCLES  = NVM_READ_CYCLES,
  parameter int WORDS        = 32
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // byte register port from serial interface
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // activity
  output logic             write_busy_o,
  output logic             read_busy_o
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // whole state but the storage arrays in one struct
  typedef struct packed {
    logic [7:0]  wr_addr;
    logic [15:0] wd_upper;
    logic [15:0] wd_lower;
    logic [7:0]  rd_addr;
    logic [15:0] rd_upper;
    logic [15:0] rd_lower;
    logic        write_done;
    logic        read_done;
    logic        launch_hold;
    op_state_t   state;
    logic [CW-1:0] count;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        wbusy;
    logic        rbusy;
  } state_t;

  state_t q;
  state_t next_q;
  byte_req_t req;

  // storage arrays, array and shadow
  logic [31:0] nvm_mem    [WORDS];
  logic [31:0] shadow_mem [WORDS];

  logic        wr_in_nvm;
  logic        wr_in_shadow;
  logic        rd_in_nvm;
  logic        rd_in_shadow;
  logic [15:0] read_word;
  logic [7:0]  reg_base;
  logic        store_en;

  assign req.wr    = reg_wr_i;
  assign req.rd    = reg_rd_i;
  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;

  // target decode, shadow is array offset by 0x40
  assign wr_in_nvm    = (q.wr_addr >= NVM_LO) && (q.wr_addr <= NVM_HI);
  assign wr_in_shadow = (q.wr_addr >= SHADOW_LO) && (q.wr_addr <= SHADOW_HI);
  assign rd_in_nvm    = (q.rd_addr >= NVM_LO) && (q.rd_addr <= NVM_HI);
  assign rd_in_shadow = (q.rd_addr >= SHADOW_LO) && (q.rd_addr <= SHADOW_HI);
  assign reg_base     = {req.addr[7:1], 1'b0};

  // 16-bit register view for reads
  always_comb begin
    read_word = RESET_WORD;
    case (reg_base)
      ADDR_NULL_WORD:   read_word = RESET_WORD;
      ADDR_EXT_WR_ADDR: read_word = {8'h00, q.wr_addr};
      ADDR_EXT_WD_UP:   read_word = q.wd_upper;
      ADDR_EXT_WD_LO:   read_word = q.wd_lower;
      ADDR_EXT_WCS: begin
        read_word[BUSY_BIT] = (q.state == ST_WRITE);
        read_word[DONE_BIT] = q.write_done;
      end
      ADDR_EXT_RD_ADDR: read_word = {8'h00, q.rd_addr};
      ADDR_EXT_RCS: begin
        read_word[BUSY_BIT] = (q.state == ST_READ);
        read_word[DONE_BIT] = q.read_done;
      end
      ADDR_EXT_RD_UP:   read_word = q.rd_upper;
      ADDR_EXT_RD_LO:   read_word = q.rd_lower;
      default:          read_word = RESET_WORD;
    endcase
  end

  // next-state logic
  always_comb begin
    next_q          = q;
    next_q.rvalid   = 1'b0;
    store_en        = 1'b0;
    // byte reads: even address is msb byte
    if (req.rd) begin
      next_q.rdata  = req.addr[0] ? read_word[7:0] : read_word[15:8];
      next_q.rvalid = 1'b1;
    end
    // operation sequencing
    case (q.state)
      ST_IDLE: begin
        next_q.count = '0;
      end
      ST_WRITE: begin
        next_q.count = q.count + 1'b1;
        if (!wr_in_nvm || (q.count >= CW'(WRITE_CYCLES - 1))) begin
          store_en          = 1'b1;
          next_q.write_done = 1'b1;
          next_q.state      = ST_IDLE;
          next_q.count      = '0;
        end
      end
      ST_READ: begin
        next_q.count = q.count + 1'b1;
        if (!rd_in_nvm || (q.count >= CW'(READ_CYCLES - 1))) begin
          if (rd_in_nvm) begin
            next_q.rd_upper = nvm_mem[q.rd_addr[4:0]][31:16];
            next_q.rd_lower = nvm_mem[q.rd_addr[4:0]][15:0];
          end else if (rd_in_shadow) begin
            next_q.rd_upper = shadow_mem[q.rd_addr[4:0]][31:16];
            next_q.rd_lower = shadow_mem[q.rd_addr[4:0]][15:0];
          end else begin
            next_q.rd_upper = RESET_WORD;
            next_q.rd_lower = RESET_WORD;
          end
          next_q.read_done = 1'b1;
          next_q.state     = ST_IDLE;
          next_q.count     = '0;
        end
      end
      default: next_q.state = ST_IDLE;
    endcase
    // register writes, byte wide; msb byte at even address
    if (req.wr) begin
      case (reg_base)
        ADDR_EXT_WR_ADDR: if (req.addr[0]) next_q.wr_addr = req.wdata;
        ADDR_EXT_WD_UP: begin
          if (req.addr[0]) next_q.wd_upper[7:0] = req.wdata;
          else next_q.wd_upper[15:8] = req.wdata;
        end
        ADDR_EXT_WD_LO: begin
          if (req.addr[0]) next_q.wd_lower[7:0] = req.wdata;
          else next_q.wd_lower[15:8] = req.wdata;
        end
        ADDR_EXT_RD_ADDR: if (req.addr[0]) next_q.rd_addr = req.wdata;
        ADDR_EXT_WCS: begin
          if (!req.addr[0] && req.wdata[LAUNCH_BIT-8] && q.state == ST_IDLE) begin
            next_q.state      = ST_WRITE;
            next_q.write_done = 1'b0;
            next_q.count      = '0;
          end
        end
        ADDR_EXT_RCS: begin
          if (!req.addr[0] && req.wdata[LAUNCH_BIT-8]) begin
            // a write finishing this cycle keeps its done flag (set wins)
            if (q.state != ST_WRITE) next_q.write_done = 1'b0;
            if (q.state == ST_IDLE) begin
              next_q.state     = ST_READ;
              next_q.read_done = 1'b0;
              next_q.count     = '0;
            end
          end
        end
        default: ;
      endcase
    end
    // busy flags registered so the outputs come from flops
    next_q.wbusy = (next_q.state == ST_WRITE);
    next_q.rbusy = (next_q.state == ST_READ);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q          <= '0;
      q.state    <= ST_IDLE;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  // array and shadow storage, word commits at end of write
  always_ff @(posedge clk_i) begin
    if (ce_i && store_en) begin
      if (wr_in_nvm) begin
        nvm_mem[q.wr_addr[4:0]] <= {q.wd_upper, q.wd_lower};
      end else if (wr_in_shadow) begin
        shadow_mem[q.wr_addr[4:0]] <= {q.wd_upper, q.wd_lower};
      end
    end
  end

  // outputs straight from flops
  assign reg_rdata_o  = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign write_busy_o = q.wbusy;
  assign read_busy_o  = q.rbusy;

endmodule : extended_nvm_shadow_access

/* File: hdl/nvm_access_pkg.sv */
package nvm_access_pkg;

  // register byte addresses (msb byte of each 16-bit register)
  localparam logic [7:0] ADDR_NULL_WORD   = 8'h00;
  localparam logic [7:0] ADDR_EXT_WR_ADDR = 8'h02;
  localparam logic [7:0] ADDR_EXT_WD_UP   = 8'h04;
  localparam logic [7:0] ADDR_EXT_WD_LO   = 8'h06;
  localparam logic [7:0] ADDR_EXT_WCS     = 8'h08;
  localparam logic [7:0] ADDR_EXT_RD_ADDR = 8'h0A;
  localparam logic [7:0] ADDR_EXT_RCS     = 8'h0C;
  localparam logic [7:0] ADDR_EXT_RD_UP   = 8'h0E;
  localparam logic [7:0] ADDR_EXT_RD_LO   = 8'h10;

  // control/status field positions
  localparam int LAUNCH_BIT = 15;
  localparam int BUSY_BIT   = 8;
  localparam int DONE_BIT   = 0;

  // target address ranges
  localparam logic [7:0] NVM_LO    = 8'h00;
  localparam logic [7:0] NVM_HI    = 8'h1F;
  localparam logic [7:0] SHADOW_LO = 8'h40;
  localparam logic [7:0] SHADOW_HI = 8'h5F;

  // timing
  localparam int CLK_MHZ          = 250;
  localparam int NVM_WRITE_MS     = 24;
  localparam int NVM_READ_US      = 2;
  localparam int NVM_WRITE_CYCLES = NVM_WRITE_MS * 1000 * CLK_MHZ;
  localparam int NVM_READ_CYCLES  = NVM_READ_US * CLK_MHZ;
  localparam int SHADOW_CYCLES    = 1;

  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } op_state_t;

  // byte-wide register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } byte_req_t;

endpackage : nvm_access_pkg

/* File: verif/nvm_access_chk.sv */
`timescale 1ns/100ps
module nvm_access_chk #(
  parameter int WRITE_CYCLES = 20
) (
  // watched ports
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       ce_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       write_busy_o,
  input wire logic       read_busy_o
);
  localparam int WMAX = WRITE_CYCLES + 4;
  // accepted byte read, accepted launch while idle
  wire logic rd = reg_rd_i && ce_i;
  wire logic go = reg_wr_i && ce_i && reg_wdata_i[7] && !write_busy_o && !read_busy_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // byte port and status relations
  property p_ans; rd |=> reg_rvalid_o; endproperty
  a_ans: assert property (p_ans) else $error("no read answer");
  property p_null; rd && reg_addr_i < 8'h02 |=> reg_rdata_o == 8'h00; endproperty
  a_null: assert property (p_null) else $error("null word not zero");
  property p_wgo; go && reg_addr_i == 8'h08 |=> write_busy_o; endproperty
  a_wgo: assert property (p_wgo) else $error("write launch lost");
  property p_rgo; go && reg_addr_i == 8'h0C |=> read_busy_o; endproperty
  a_rgo: assert property (p_rgo) else $error("read launch lost");
  property p_lnch; rd && reg_addr_i inside {8'h08, 8'h0C} |=> !reg_rdata_o[7]; endproperty
  a_lnch: assert property (p_lnch) else $error("launch bit reads 1");
  property p_wip; rd && reg_addr_i == 8'h08 |=> reg_rdata_o[0] == $past(write_busy_o); endproperty
  a_wip: assert property (p_wip) else $error("write busy bit wrong");
  property p_rip; rd && reg_addr_i == 8'h0C |=> reg_rdata_o[0] == $past(read_busy_o); endproperty
  a_rip: assert property (p_rip) else $error("read busy bit wrong");
  property p_wlen; $rose(write_busy_o) |-> ##[1:WMAX] !write_busy_o; endproperty
  a_wlen: assert property (p_wlen) else $error("write never ends");
endmodule : nvm_access_chk

bind extended_nvm_shadow_access nvm_access_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .write_busy_o(write_busy_o), .read_busy_o(read_busy_o));

/* File: verif/nvm_host.sv */
`timescale 1ns/100ps
module nvm_host (
  // byte port
  input  wire logic       clk_i,
  input  wire logic       busy_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      data_o
);
  logic [7:0] exp_q[$];
  initial begin
    {wr_o, rd_o, addr_o, data_o} = 18'h0;
  end
  // one byte strobe across one rising edge, lines inverted after
  task automatic op(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {rd_o, wr_o, addr_o, data_o} = {r, !r, a, d};
    if (r) exp_q.push_back(d);
    @(negedge clk_i);
    {rd_o, wr_o, addr_o, data_o} = {2'b00, ~a, ~d};
  endtask : op
  // msb byte at the even address
  task automatic w16(input logic r, input logic [7:0] a, input logic [15:0] d);
    op(r, a, d[15:8]);
    op(r, a + 8'h01, d[7:0]);
  endtask : w16
  // nothing changes until busy drops or 100 more cycles pass
  task automatic wait_idle;
    @(negedge clk_i);
    for (int i = 0; i < 100 && busy_i; i++) @(negedge clk_i);
  endtask : wait_idle
endmodule : nvm_host

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic        reg_rvalid_o;
  logic        write_busy_o;
  logic        read_busy_o;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  exp;
  logic [7:0]  tgt [5];
  logic [31:0] mem [logic [7:0]];
  int          n_mismatch = 0;
  int          checked = 0;
  always #2 clk_i = ~clk_i;
  extended_nvm_shadow_access #(.WRITE_CYCLES(20), .READ_CYCLES(10)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .write_busy_o(write_busy_o), .read_busy_o(read_busy_o));
  nvm_host u_host (.clk_i(clk_i), .busy_i(write_busy_o | read_busy_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .data_o(reg_wdata_i));
  // oldest note against each answered byte
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      exp = u_host.exp_q.size() ? u_host.exp_q.pop_front() : 8'hXX;
      checked++;
      if (reg_rdata_o !== exp) begin
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, reg_rdata_o, exp);
      end
    end
  end
  task automatic final_report;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // cut a hang short
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
  // array ends, shadow ends, one random array word
  initial begin
    logic [31:0] d;
    void'($urandom(32'h9D34));
    tgt = '{8'h00, 8'h1F, 8'h40, 8'h5F, 8'h00};
    tgt[4] = 8'h01 + 8'($urandom % 30);
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    u_host.op(0, 8'h01, 8'h5A);
    u_host.w16(1, 8'h00, 16'h0000);
    foreach (tgt[i]) begin
      d = $urandom;
      mem[tgt[i]] = d;
      u_host.w16(0, 8'h02, {8'($urandom), tgt[i]});
      u_host.w16(0, 8'h04, d[31:16]);
      u_host.w16(0, 8'h06, d[15:0]);
      u_host.w16(1, 8'h02, {8'h00, tgt[i]});
      u_host.w16(1, 8'h04, d[31:16]);
      u_host.w16(1, 8'h06, d[15:0]);
      u_host.op(0, 8'h08, 8'h80);
      // freeze a few cycles while the write runs
      ce_i = 1'b0;
      repeat (3) @(negedge clk_i);
      ce_i = 1'b1;
      if (tgt[i] < 8'h20) u_host.w16(1, 8'h08, 16'h0100);
      u_host.wait_idle();
      u_host.w16(1, 8'h08, 16'h0001);
    end
    foreach (tgt[i]) begin
      d = mem[tgt[i]];
      u_host.w16(0, 8'h0A, {8'($urandom), tgt[i]});
      u_host.w16(1, 8'h0A, {8'h00, tgt[i]});
      u_host.op(0, 8'h0C, 8'h80);
      if (tgt[i] < 8'h20) u_host.w16(1, 8'h0C, 16'h0100);
      u_host.w16(1, 8'h08, 16'h0000);
      u_host.wait_idle();
      u_host.w16(1, 8'h0C, 16'h0001);
      u_host.w16(1, 8'h0E, d[31:16]);
      u_host.w16(1, 8'h10, d[15:0]);
    end
    repeat (4) @(negedge clk_i);
    final_report();
  end
endmodule : tb
